// file: shared/msif_pkg.sv
// Constants, field layouts and carriers of the motion interrupt status block.
// Assumes one 100 MHz clock and a byte-wide read port from the host side.
// Function
// - Four read-only status bytes from base offset
// - Flag sets when its function triggers
// - Latch setting picks permanent, temporary or none
// - Flag asserts only with function enabled
// - Byte 0/1 flag layout, reserved bits zero
// - Byte 2 bit 7 tap sign
// - Byte 2 bits 6..4 tap axes z,y,x
// - Byte 2 bit 3 any-motion slope sign
// - Byte 2 bits 2..0 any-motion axes
// - Byte 3 bit 7 flat, gated by enable
// - Byte 3 bit 6 z orientation
// - Byte 3 bits 5..4 x-y orientation
// - Orientation shows present value, never latched
// - Orientation frozen while blocking condition active
// - Byte 3 bit 3 high-g sign
// - Byte 3 bits 2..0 high-g axes
package msif_pkg;

   localparam logic [7:0] STATUS_ADDR_B0 = 8'h1C;
   localparam logic [7:0] STATUS_ADDR_B1 = 8'h1D;
   localparam logic [7:0] STATUS_ADDR_B2 = 8'h1E;
   localparam logic [7:0] STATUS_ADDR_B3 = 8'h1F;
   localparam logic [7:0] READ_IDLE_VAL = 8'h00;

   localparam logic [3:0] LATCH_NONE = 4'h0;
   localparam logic [3:0] LATCH_PERM = 4'hF;

   localparam int CLK_PERIOD_NS = 10;
   localparam int TEMP_UNIT_NS = 1000;
   localparam int TEMP_UNIT_CYC = (TEMP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CNT_W = 12;

   // Flags word: byte 1 in the upper half, byte 0 in the lower
   typedef struct packed {
      logic nomo;
      logic fifo_wm;
      logic fifo_full;
      logic data_rdy;
      logic low_g;
      logic high_g;
      logic [1:0] rsvd;
      logic flat;
      logic orient;
      logic s_tap;
      logic d_tap;
      logic pmu_trig;
      logic anym;
      logic sigmot;
      logic step;
   } msif_flags_t;

   typedef struct packed {
      logic sign;
      logic [2:0] axis;
   } msif_trig_detail_t;

   typedef struct packed {
      logic z;
      logic [1:0] xy;
   } msif_orient_t;

   typedef struct packed {
      msif_trig_detail_t tap;
      msif_trig_detail_t anym;
   } msif_detail2_t;

   typedef struct packed {
      logic flat;
      msif_orient_t orient;
      msif_trig_detail_t high;
   } msif_detail3_t;

endpackage : msif_pkg

// file: logic/msif_latch_cell.sv
// One status flag with its latch behaviour.
// Assumes cond is the function's live trigger level and clear a one-cycle pulse.
`timescale 1ns/1ns
module msif_latch_cell (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cond,
   input wire logic enable,
   input wire logic [3:0] latch_mode,
   input wire logic latch_clear,
   output logic flag_q
);
   import msif_pkg::*;

   typedef struct packed {
      logic flag;
      logic [HOLD_CNT_W-1:0] cnt;
   } msif_cell_st_t;

   msif_cell_st_t st_q;
   msif_cell_st_t st_d;
   logic active;
   logic [HOLD_CNT_W-1:0] hold_len;

   assign active = cond & enable;
   assign hold_len = HOLD_CNT_W'(int'(latch_mode) * TEMP_UNIT_CYC);
   assign flag_q = st_q.flag;

   always_comb begin
      st_d = st_q;
      case (latch_mode)
         LATCH_NONE: begin
            st_d.flag = active;
            st_d.cnt = '0;
         end
         LATCH_PERM: begin
            st_d.cnt = '0;
            if (active) begin
               st_d.flag = 1'b1;
            end else if (latch_clear) begin
               st_d.flag = 1'b0;
            end
         end
         default: begin
            if (active) begin
               st_d.flag = 1'b1;
               st_d.cnt = hold_len;
            end else if (latch_clear || st_q.cnt == '0) begin
               st_d.flag = 1'b0;
               st_d.cnt = '0;
            end else begin
               st_d.cnt = st_q.cnt - 1'b1;
               st_d.flag = (st_q.cnt != HOLD_CNT_W'(1));
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   none_follow_a: assert property (latch_mode == LATCH_NONE |=> flag_q == $past(active))
      else $error("unlatched flag does not follow its trigger");
   perm_hold_a: assert property (latch_mode == LATCH_PERM && flag_q && !latch_clear
      && $stable(latch_mode) |=> flag_q)
      else $error("permanent flag dropped without clear");
   set_wins_a: assert property (active && latch_mode != LATCH_NONE |=> flag_q)
      else $error("trigger lost against clear");
   enable_gate_a: assert property (!flag_q ##1 flag_q |-> $past(active))
      else $error("flag rose without enabled trigger");

endmodule : msif_latch_cell

// file: logic/msif_status_top.sv
// Four-byte read-only interrupt status block with a byte read port.
// Assumes detection logic drives trigger levels and details synchronously.
`timescale 1ns/1ns
module msif_status_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire msif_pkg::msif_flags_t int_cond,
   input wire msif_pkg::msif_flags_t int_enable,
   input wire logic [3:0] latch_mode,
   input wire logic latch_clear,
   input wire msif_pkg::msif_trig_detail_t tap_detail,
   input wire msif_pkg::msif_trig_detail_t anym_detail,
   input wire msif_pkg::msif_trig_detail_t high_detail,
   input wire logic flat_now,
   input wire msif_pkg::msif_orient_t orient_now,
   input wire logic orient_block,
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data_q,
   output logic rd_valid_q
);
   import msif_pkg::*;

   typedef struct packed {
      msif_detail2_t det2;
      msif_detail3_t det3;
      logic [7:0] rd_data;
      logic rd_valid;
   } msif_top_st_t;

   msif_top_st_t st_q;
   msif_top_st_t st_d;
   logic [15:0] cond_vec;
   logic [15:0] en_vec;
   logic [15:0] flag_vec;
   msif_flags_t flags;
   logic tap_hit;
   logic anym_hit;
   logic high_hit;

   assign cond_vec = int_cond;
   assign en_vec = int_enable;

   // One latch cell per flag position, reserved positions tied low
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_flag
         if (gi == 8 || gi == 9) begin : g_rsvd
            assign flag_vec[gi] = 1'b0;
         end else begin : g_cell
            msif_latch_cell u_cell (
               .clk(clk),
               .sys_rst(sys_rst),
               .cond(cond_vec[gi]),
               .enable(en_vec[gi]),
               .latch_mode(latch_mode),
               .latch_clear(latch_clear),
               .flag_q(flag_vec[gi])
            );
         end
      end
   endgenerate

   assign flags = flag_vec;

   // Detail capture on an enabled trigger
   assign tap_hit = (int_cond.s_tap & int_enable.s_tap) | (int_cond.d_tap & int_enable.d_tap);
   assign anym_hit = int_cond.anym & int_enable.anym;
   assign high_hit = int_cond.high_g & int_enable.high_g;

   always_comb begin
      st_d = st_q;
      if (tap_hit) begin
         st_d.det2.tap = tap_detail;
      end
      if (anym_hit) begin
         st_d.det2.anym = anym_detail;
      end
      if (high_hit) begin
         st_d.det3.high = high_detail;
      end
      st_d.det3.flat = flat_now & int_enable.flat;
      if (!orient_block) begin
         st_d.det3.orient = orient_now;
      end
      st_d.rd_valid = rd_en;
      st_d.rd_data = READ_IDLE_VAL;
      if (rd_en) begin
         case (rd_addr)
            STATUS_ADDR_B0: st_d.rd_data = flag_vec[7:0];
            STATUS_ADDR_B1: st_d.rd_data = flag_vec[15:8];
            STATUS_ADDR_B2: st_d.rd_data = st_q.det2;
            STATUS_ADDR_B3: st_d.rd_data = st_q.det3;
            default: st_d.rd_data = READ_IDLE_VAL;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_data_q = st_q.rd_data;
   assign rd_valid_q = st_q.rd_valid;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   read_latency_a: assert property (rd_en |=> rd_valid_q ##1 (rd_valid_q == $past(rd_en)))
      else $error("read answer not one cycle after request");
   unmapped_zero_a: assert property (rd_en && (rd_addr < STATUS_ADDR_B0 ||
      rd_addr > STATUS_ADDR_B3) |=> rd_data_q == READ_IDLE_VAL)
      else $error("unmapped read not zero");
   byte0_read_a: assert property (rd_en && rd_addr == STATUS_ADDR_B0 |=>
      rd_data_q == $past(flag_vec[7:0]))
      else $error("byte 0 read mismatch");
   rsvd_zero_a: assert property (rd_en && rd_addr == STATUS_ADDR_B1 |=>
      rd_data_q[1:0] == 2'b00 && rd_data_q[7:2] == $past(flag_vec[15:10]))
      else $error("byte 1 read mismatch");
   tap_capture_a: assert property (tap_hit |=> st_q.det2.tap == $past(tap_detail))
      else $error("tap detail not captured");
   anym_capture_a: assert property (anym_hit |=> st_q.det2.anym == $past(anym_detail))
      else $error("any-motion detail not captured");
   high_capture_a: assert property (!high_hit ##1 !high_hit |=> $stable(st_q.det3.high))
      else $error("high-g detail moved without trigger");
   flat_track_a: assert property (1'b1 |=> st_q.det3.flat == $past(flat_now & int_enable.flat))
      else $error("flat bit wrong");
   orient_hold_a: assert property (orient_block [*2] |-> $stable(st_q.det3.orient))
      else $error("orientation moved while blocked");
   orient_follow_a: assert property (!orient_block |=> st_q.det3.orient == $past(orient_now))
      else $error("orientation not current");

   read_b3_c: cover property (rd_en && rd_addr == STATUS_ADDR_B3 ##1 rd_data_q != READ_IDLE_VAL);
   flag_read_c: cover property (rd_en && rd_addr == STATUS_ADDR_B0 ##1 rd_data_q[5]);
   orient_block_c: cover property (orient_block [*3] ##1 !orient_block);
   temp_latch_c: cover property (latch_mode != LATCH_NONE && latch_mode != LATCH_PERM
      && flags.step ##1 !flags.step);

endmodule : msif_status_top

// file: tb/msif_host_model.sv
// Host side of the status block: issues byte reads and collects answers.
// Assumes the read contract: answer registered on the edge that takes the request.
`timescale 1ns/1ns
module msif_host_model (
   input wire logic clk,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data_q,
   input wire logic rd_valid_q
);
   initial begin
      rd_en = 1'b0;
      rd_addr = 8'h00;
   end

   // One read: request held one cycle, answer sampled just after the taken edge
   task read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      #1;
      rd_en = 1'b1;
      rd_addr = a;
      @(posedge clk);
      #1;
      rd_en = 1'b0;
      rd_addr = ~a;
      d = rd_data_q;
      v = rd_valid_q;
   endtask : read_byte
endmodule : msif_host_model

// file: tb/msif_status_top_tb_top.sv
// Self-checking bench of the interrupt status block.
// Assumes a host model on the read port and bench-driven trigger inputs.
`timescale 1ns/1ns
module msif_status_top_tb_top;
   import msif_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic latch_clear = 1'b0;
   logic flat_now = 1'b0;
   logic orient_block = 1'b0;
   logic [3:0] latch_mode = 4'h0;
   msif_flags_t cond = 16'h0000;
   msif_flags_t en = 16'h0000;
   msif_trig_detail_t tap = 4'h0, anym = 4'h0, high = 4'h0;
   msif_orient_t orient = 3'h0, old;
   logic rd_en, rd_valid_q, v;
   logic [7:0] rd_addr, rd_data_q, d;
   int error_cnt = 0, n_tests = 0, cyc = 0;

   always #5 clk = ~clk;

   msif_status_top i_dut (.clk(clk), .sys_rst(sys_rst), .int_cond(cond), .int_enable(en),
      .latch_mode(latch_mode), .latch_clear(latch_clear), .tap_detail(tap),
      .anym_detail(anym), .high_detail(high), .flat_now(flat_now), .orient_now(orient),
      .orient_block(orient_block), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
   msif_host_model i_host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task print_verdict;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict

   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task rd(input logic [7:0] a, input logic [7:0] exp);
      i_host.read_byte(a, d, v);
      check({7'h00, v}, 8'h01);
      check(d, exp);
   endtask : rd

   function automatic logic [7:0] exp_d3(logic f, msif_orient_t o, msif_trig_detail_t h);
      return {f, o, h};
   endfunction : exp_d3

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict;
      end
   end

   initial begin
      void'($urandom(47803));
      step(4);
      sys_rst = 1'b0;
      for (int a = 8'h1C; a < 8'h20; a++) rd(8'(a), 8'h00);
      rd(8'h1B, 8'h00);
      rd(8'h20, 8'h00);
      for (int i = 0; i < 16; i++) begin
         en = 16'hFFFF;
         cond = 16'(1 << i);
         step(2);
         rd(i < 8 ? 8'h1C : 8'h1D, (i == 8 || i == 9) ? 8'h00 : 8'(1 << (i % 8)));
         cond = 16'h0000;
         en = ~16'(1 << i);
         step(1);
         cond = 16'(1 << i);
         step(2);
         rd(i < 8 ? 8'h1C : 8'h1D, 8'h00);
         cond = 16'h0000;
      end
      en = 16'hFFFF;
      for (int k = 0; k < 8; k++) begin
         tap = 4'($urandom);
         anym = 4'($urandom);
         high = 4'($urandom);
         flat_now = 1'($urandom);
         orient = {1'($urandom), 2'(k)};
         cond = 16'h0424;
         step(2);
         rd(8'h1E, {tap, anym});
         rd(8'h1F, exp_d3(flat_now, orient, high));
      end
      cond = 16'h0000;
      en.flat = 1'b0;
      flat_now = 1'b1;
      step(2);
      rd(8'h1F, exp_d3(1'b0, orient, high));
      en = 16'hFFFF;
      orient_block = 1'b1;
      old = orient;
      orient = ~orient;
      step(2);
      rd(8'h1F, exp_d3(1'b1, old, high));
      orient_block = 1'b0;
      step(2);
      rd(8'h1F, exp_d3(1'b1, orient, high));
      latch_mode = 4'hF;
      cond = 16'h0001;
      step(1);
      cond = 16'h0000;
      orient = ~orient;
      step(5);
      rd(8'h1C, 8'h01);
      rd(8'h1F, exp_d3(1'b1, orient, high));
      latch_clear = 1'b1;
      step(1);
      latch_clear = 1'b0;
      step(1);
      rd(8'h1C, 8'h00);
      latch_mode = 4'h1;
      cond = 16'h0001;
      step(1);
      cond = 16'h0000;
      step(50);
      rd(8'h1C, 8'h01);
      step(100);
      rd(8'h1C, 8'h00);
      print_verdict;
   end
endmodule : msif_status_top_tb_top
